// file: src/ir_tx_pkg.sv
// Package for the infrared pulse-distance transmitter
// Assumes a 125 MHz system clock; all timing counts derive from it
package ir_tx_pkg;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int unsigned CLK_HZ = 125000000;
	localparam int unsigned CARRIER_HZ = 38000;
	localparam int unsigned CARRIER_CYCLES = CLK_HZ / CARRIER_HZ;
	localparam int unsigned CARRIER_HALF = CARRIER_CYCLES / 2;
	// Times in nanoseconds, as printed
	localparam int unsigned LONG_MARK_NS = 624000;
	localparam int unsigned SHORT_MARK_NS = 562500;
	localparam int unsigned ONE_BIT_NS = 2250000;
	localparam int unsigned ZERO_BIT_NS = 1125000;
	localparam int unsigned LEADER_HALF_NS = 4500000;
	localparam int unsigned CLK_PERIOD_NS = 1000000000 / CLK_HZ;
	// Cycle counts
	localparam int unsigned LONG_MARK_CYC = LONG_MARK_NS / CLK_PERIOD_NS;
	localparam int unsigned SHORT_MARK_CYC = (SHORT_MARK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned ONE_BIT_CYC = ONE_BIT_NS / CLK_PERIOD_NS;
	localparam int unsigned ZERO_BIT_CYC = ZERO_BIT_NS / CLK_PERIOD_NS;
	localparam int unsigned LEADER_HALF_CYC = LEADER_HALF_NS / CLK_PERIOD_NS;
	localparam int unsigned TMR_W = 24;

	// ************************************************************
	// Frame layout and key codes
	// ************************************************************
	localparam int unsigned FRAME_BITS = 32;
	localparam logic [7:0] LONG_VOL_UP = 8'h07;
	localparam logic [7:0] SHORT_VOL_UP = 8'h1f;

	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_LEAD_MARK = 3'b001,
		ST_LEAD_SPACE = 3'b010,
		ST_BIT = 3'b011,
		ST_END_MARK = 3'b100
	} tx_state_type;

	typedef struct packed {
		logic [15:0] address;
		logic [7:0] command;
	} ir_request_type;

	typedef struct packed {
		logic busy;
		logic bit_done;
		logic mark_done;
	} ir_status_type;

endpackage

// file: src/ir_pulse_distance_transmitter.sv
// Infrared pulse-distance transmitter: carrier generator, bit timer, sequencer
// Assumes requests synchronous to sys_clk_i; ir_led_o drives the LED stage
// Notes on behaviour
// RULE1: Format chosen by build parameter; long-address format is the default.
// RULE2: Long format sends 16-bit address, 8-bit command, inverted command.
// RULE3: Long format marks are 624 us bursts of 38 kHz carrier.
// RULE4: One bit lasts 2.25 ms, zero bit 1.125 ms, mark then space.
// RULE5: Quarter or third carrier duty recommended; this build uses half.
// RULE6: Long format frame opens with 4.5 ms carrier and 4.5 ms silence.
// RULE7: Short format sends address, inverse address, command, inverse command.
// RULE8: Short format marks are 562.5 us bursts of carrier.
// RULE9: Free-running 38 kHz carrier gated by mark and space timing.
// RULE10: Carrier runs at half duty and raises no events of its own.
// RULE11: Bit timer reloaded per bit; terminal count ends the bit.
// RULE12: Compare event ends the mark; carrier gated off for the rest.
// RULE13: Long format zero is 0.624 ms carrier inside 1.125 ms window.
// RULE14: Terminal-count and compare events both drive the sequencer.
// RULE15: Frame starts only when link not connected and command valid.
// RULE16: Command carries 8-bit key code, e.g. volume-up 0x07 or 0x1f.
// RULE17: Fields go least significant bit first; inverses are complements.
// RULE18: A final mark follows the last bit, then output returns idle.
`timescale 1ns/1ps
`default_nettype none

module ir_pulse_distance_transmitter
	import ir_tx_pkg::*;
#(
	parameter bit short_address_format_select = 1'b0, // [RULE1]
	parameter int unsigned LEADER_CYC = LEADER_HALF_CYC,
	parameter int unsigned ONE_CYC = ONE_BIT_CYC,
	parameter int unsigned ZERO_CYC = ZERO_BIT_CYC,
	parameter int unsigned LONG_MARK = LONG_MARK_CYC,
	parameter int unsigned SHORT_MARK = SHORT_MARK_CYC
)
(
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	// Request
	input wire logic link_connected_i,
	input wire logic command_valid_i,
	input wire ir_request_type request_i,
	// LED and status
	output logic ir_led_o,
	output ir_status_type status_o
);

	// ************************************************************
	// Reset release
	// ************************************************************
	logic rst_meta_n;
	logic rst_n;

	// Two-stage release of the asynchronous reset
	always_ff @(posedge sys_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			rst_meta_n <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_meta_n <= 1'b1;
			rst_n <= rst_meta_n;
		end
	end

	// ************************************************************
	// Carrier generator
	// ************************************************************
	localparam logic [TMR_W-1:0] CAR_LAST = TMR_W'(CARRIER_CYCLES - 1);
	localparam logic [TMR_W-1:0] CAR_HALF = TMR_W'(CARRIER_HALF);
	localparam logic [TMR_W-1:0] MARK_LEN = short_address_format_select ?
		TMR_W'(SHORT_MARK) : TMR_W'(LONG_MARK); // [RULE3] [RULE8]

	logic [TMR_W-1:0] car_cnt;
	logic [TMR_W-1:0] next_car_cnt;
	logic carrier;

	// Free-running counter, no events raised
	always_comb
	begin
		next_car_cnt = (car_cnt == CAR_LAST) ? '0 : car_cnt + 1'b1; // [RULE9] [RULE10]
	end

	always_ff @(posedge sys_clk_i or negedge rst_n)
	begin
		if (!rst_n)
			car_cnt <= '0;
		else
			car_cnt <= next_car_cnt;
	end

	assign carrier = (car_cnt < CAR_HALF); // [RULE10] [RULE5]

	// ************************************************************
	// Sequencer and bit period timer
	// ************************************************************
	tx_state_type state;
	tx_state_type next_state;
	logic [TMR_W-1:0] bit_period_timer;
	logic [TMR_W-1:0] next_bit_period_timer;
	logic [TMR_W-1:0] period;
	logic [TMR_W-1:0] next_period;
	logic [FRAME_BITS-1:0] shreg;
	logic [FRAME_BITS-1:0] next_shreg;
	logic [5:0] bit_cnt;
	logic [5:0] next_bit_cnt;
	logic gate;
	logic next_gate;
	logic led;
	logic next_led;
	ir_status_type stat;
	ir_status_type next_stat;
	logic tc_event;
	logic cmp_event;
	logic [FRAME_BITS-1:0] frame;

	// Frame assembly, least significant bit leaves first
	always_comb
	begin
		if (short_address_format_select) // [RULE7] [RULE17]
			frame = {~request_i.command, request_i.command,
				~request_i.address[7:0], request_i.address[7:0]};
		else // [RULE2] [RULE17] [RULE16]
			frame = {~request_i.command, request_i.command, request_i.address};
	end

	// Timer events
	assign tc_event = (bit_period_timer == period - 1'b1); // [RULE11] [RULE14]
	assign cmp_event = (bit_period_timer == MARK_LEN - 1'b1); // [RULE12] [RULE14]

	// Next-state logic
	always_comb
	begin
		next_state = state;
		next_bit_period_timer = bit_period_timer + 1'b1;
		next_period = period;
		next_shreg = shreg;
		next_bit_cnt = bit_cnt;
		next_gate = gate;
		next_stat = '0;
		next_stat.busy = (state != ST_IDLE);
		case (state)
			ST_IDLE:
			begin
				next_bit_period_timer = '0;
				next_gate = 1'b0;
				if (!link_connected_i && command_valid_i) // [RULE15]
				begin
					next_shreg = frame;
					next_bit_cnt = '0;
					next_stat.busy = 1'b1;
					if (short_address_format_select)
					begin
						// Short format starts directly with data bits
						next_state = ST_BIT;
						next_period = frame[0] ? TMR_W'(ONE_CYC) : TMR_W'(ZERO_CYC);
						next_gate = 1'b1;
					end
					else
					begin
						next_state = ST_LEAD_MARK; // [RULE6]
						next_period = TMR_W'(LEADER_CYC);
						next_gate = 1'b1;
					end
				end
			end
			ST_LEAD_MARK:
			begin
				if (bit_period_timer == TMR_W'(LEADER_CYC) - 1'b1) // [RULE6]
				begin
					next_bit_period_timer = '0;
					next_gate = 1'b0;
					next_state = ST_LEAD_SPACE;
				end
			end
			ST_LEAD_SPACE:
			begin
				if (bit_period_timer == TMR_W'(LEADER_CYC) - 1'b1)
				begin
					next_bit_period_timer = '0;
					next_period = shreg[0] ? TMR_W'(ONE_CYC) : TMR_W'(ZERO_CYC); // [RULE11]
					next_gate = 1'b1;
					next_state = ST_BIT;
				end
			end
			ST_BIT:
			begin
				if (cmp_event)
				begin
					next_gate = 1'b0; // [RULE12] [RULE13]
					next_stat.mark_done = 1'b1;
				end
				if (tc_event) // [RULE4] [RULE11]
				begin
					next_stat.bit_done = 1'b1;
					next_bit_period_timer = '0;
					next_gate = 1'b1;
					next_shreg = {1'b0, shreg[FRAME_BITS-1:1]};
					next_bit_cnt = bit_cnt + 1'b1;
					if (bit_cnt == 6'(FRAME_BITS - 1))
						next_state = ST_END_MARK; // [RULE18]
					else
						next_period = shreg[1] ? TMR_W'(ONE_CYC) : TMR_W'(ZERO_CYC);
				end
			end
			ST_END_MARK:
			begin
				if (cmp_event) // [RULE18]
				begin
					next_stat.mark_done = 1'b1;
					next_gate = 1'b0;
					next_bit_period_timer = '0;
					next_state = ST_IDLE;
				end
			end
			default:
			begin
				next_state = ST_IDLE;
				next_gate = 1'b0;
			end
		endcase
		// LED is the carrier gated by the mark window
		next_led = next_gate & carrier; // [RULE9]
	end

	always_ff @(posedge sys_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= ST_IDLE;
			bit_period_timer <= '0;
			period <= '0;
			shreg <= '0;
			bit_cnt <= '0;
			gate <= 1'b0;
			led <= 1'b0;
			stat <= '0;
		end
		else
		begin
			state <= next_state;
			bit_period_timer <= next_bit_period_timer;
			period <= next_period;
			shreg <= next_shreg;
			bit_cnt <= next_bit_cnt;
			gate <= next_gate;
			led <= next_led;
			stat <= next_stat;
		end
	end

	// Outputs straight from flip-flops
	assign ir_led_o = led;
	assign status_o = stat;

endmodule

`default_nettype wire

// file: bench/ir_tx_chk.sv
// Port checker for the infrared transmitter
// Assumes a bind onto every transmitter instance, one clock domain
`timescale 1ns/1ps
`default_nettype none

module ir_tx_chk
	import ir_tx_pkg::*;
#(
	parameter int ONE_CYC = 20
)
(
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	// Watched ports
	input wire logic link_connected_i,
	input wire logic command_valid_i,
	input wire ir_request_type request_i,
	input wire logic ir_led_o,
	input wire ir_status_type status_o
);
	// ****
	// Helper state
	// ****
	logic [1:0] arm;
	logic [5:0] bits_sent;

	// Requests count only once the reset synchroniser has let go
	always_ff @(posedge sys_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			arm <= 2'b00;
		else
			arm <= {arm[0], 1'b1};
	end

	// Bits finished in the current frame, so the end mark is told from bit marks
	always_ff @(posedge sys_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			bits_sent <= 6'h00;
		else if (!status_o.busy || (status_o.mark_done && bits_sent == 6'(FRAME_BITS)))
			bits_sent <= 6'h00;
		else if (status_o.bit_done)
			bits_sent <= bits_sent + 6'h01;
	end

	// ****
	// Properties
	// ****
	default clocking @(posedge sys_clk_i);
	endclocking
	default disable iff (!reset_n_i);

	AST_LINK_BLOCKS: assert property (link_connected_i && $past(link_connected_i) && !status_o.busy |=> !status_o.busy)
		else $error("frame started while linked");
	AST_TAKE: assert property (arm[1] && !status_o.busy && command_valid_i && !link_connected_i |-> ##[1:2] status_o.busy)
		else $error("valid request not taken");
	AST_LED_IDLE: assert property (!status_o.busy |-> !ir_led_o)
		else $error("led on while idle");
	AST_END_MARK: assert property (status_o.mark_done && bits_sent == 6'(FRAME_BITS)
		&& !command_valid_i |=> !status_o.busy)
		else $error("busy kept after end mark");
	AST_MARK_OFF: assert property (status_o.mark_done && bits_sent != 6'(FRAME_BITS)
		|=> !ir_led_o)
		else $error("carrier not gated off after mark");
	AST_BIT_GAP: assert property (status_o.bit_done |=> !status_o.bit_done [*8])
		else $error("bit periods too short");
	AST_BIT_NEXT: assert property (status_o.bit_done |-> ##[1:ONE_CYC] (status_o.bit_done || status_o.mark_done))
		else $error("no event after bit end");
	AST_MIN_FRAME: assert property ($rose(status_o.busy) |-> status_o.busy [*8])
		else $error("frame too short");
	AST_BUSY_END: assert property ($fell(status_o.busy) |-> $past(status_o.mark_done))
		else $error("busy fell without end mark");

	COV_FRAME: cover property (status_o.mark_done);
	COV_TAKE: cover property ($rose(status_o.busy));
	COV_REFUSE: cover property (link_connected_i && command_valid_i && !status_o.busy);
endmodule

`default_nettype wire

// file: bench/ir_rx_model.sv
// Receiver model: decodes pulse-distance frames from the led line
// Assumes the carrier stays in its high phase for the whole frame
`timescale 1ns/1ps
`default_nettype none

module ir_rx_model
#(
	parameter int ONE = 20,
	parameter int ZERO = 10,
	parameter int LEADER = 40
)
(
	// Clock and led line
	input wire logic clk_i,
	input wire logic led_i,
	// Decoded frame
	output logic [31:0] word_o,
	output logic [7:0] nbits_o,
	output logic leader_o,
	output logic [7:0] mark_o
);
	int cyc = 0;
	int last = -1000;
	int run = 0;
	logic prev = 1'b0;

	initial
	begin
		word_o = 32'h0;
		nbits_o = 8'h0;
		leader_o = 1'b0;
		mark_o = 8'h0;
	end

	// Rise-to-rise gaps give bits, shifted in first bit lowest
	always @(posedge clk_i)
	begin
		cyc++;
		if (led_i && !prev)
		begin
			if (cyc - last == ONE || cyc - last == ZERO)
			begin
				word_o <= {(cyc - last == ONE), word_o[31:1]};
				nbits_o <= nbits_o + 8'h01;
			end
			else
			begin
				nbits_o <= 8'h00;
				leader_o <= (cyc - last == 2 * LEADER);
			end
			last = cyc;
			run = 0;
		end
		if (led_i)
			run++;
		if (!led_i && prev)
			mark_o <= 8'(run);
		prev = led_i;
	end
endmodule

`default_nettype wire

// file: bench/ir_pulse_distance_transmitter_tb_top.sv
// Testbench: long and short format transmitters side by side
// Assumes shortened timing; frames fit in the first carrier high phase
`timescale 1ns/1ps
`default_nettype none

module ir_pulse_distance_transmitter_tb_top;
	import ir_tx_pkg::*;
	localparam int LEAD = 40;
	localparam int ONE = 20;
	localparam int ZERO = 10;
	localparam int MARK = 4;

	logic sys_clk_i = 1'b0;
	logic reset_n_i;
	logic link_connected_i;
	logic command_valid_i;
	ir_request_type req_l;
	ir_request_type req_s;
	logic led_l;
	logic led_s;
	ir_status_type st_l;
	ir_status_type st_s;
	logic [31:0] w_l;
	logic [31:0] w_s;
	logic [7:0] nb_l;
	logic [7:0] nb_s;
	logic ld_l;
	logic ld_s;
	logic [7:0] mk_l;
	logic [7:0] mk_s;
	int n_fail = 0;
	int num_checks = 0;
	int bd_cnt = 0;
	int md_cnt = 0;

	always #4 sys_clk_i = ~sys_clk_i;

	// ****
	// Design and receivers
	// ****
	ir_pulse_distance_transmitter #(.LEADER_CYC(LEAD), .ONE_CYC(ONE), .ZERO_CYC(ZERO),
		.LONG_MARK(MARK), .SHORT_MARK(MARK)) uut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
		.link_connected_i(link_connected_i), .command_valid_i(command_valid_i),
		.request_i(req_l), .ir_led_o(led_l), .status_o(st_l));
	ir_pulse_distance_transmitter #(.short_address_format_select(1'b1), .LEADER_CYC(LEAD),
		.ONE_CYC(ONE), .ZERO_CYC(ZERO), .LONG_MARK(MARK), .SHORT_MARK(MARK)) uut_short (
		.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .link_connected_i(link_connected_i),
		.command_valid_i(command_valid_i), .request_i(req_s), .ir_led_o(led_s), .status_o(st_s));
	ir_rx_model #(.ONE(ONE), .ZERO(ZERO), .LEADER(LEAD)) rx_l (.clk_i(sys_clk_i), .led_i(led_l),
		.word_o(w_l), .nbits_o(nb_l), .leader_o(ld_l), .mark_o(mk_l));
	ir_rx_model #(.ONE(ONE), .ZERO(ZERO), .LEADER(LEAD)) rx_s (.clk_i(sys_clk_i), .led_i(led_s),
		.word_o(w_s), .nbits_o(nb_s), .leader_o(ld_s), .mark_o(mk_s));

	// Counts bit-end and mark-end events of the long transmitter, sampled off the edge
	always @(negedge sys_clk_i)
	begin
		if (st_l.bit_done === 1'b1)
			bd_cnt++;
		if (st_l.mark_done === 1'b1)
			md_cnt++;
	end

	// ****
	// Tasks
	// ****
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic tally_and_finish;
		$display("Checks %0d, mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Both formats in one go, then the decoded fields are compared
	task automatic test_frames;
		int k;
		req_l = '{address: 16'ha53c, command: LONG_VOL_UP};
		req_s = '{address: 16'h0096, command: SHORT_VOL_UP};
		command_valid_i = 1'b1;
		@(negedge sys_clk_i);
		// Request held and altered while busy: must be ignored
		req_l.command = 8'h00;
		req_s.address = 16'h0000;
		repeat (4) @(negedge sys_clk_i);
		command_valid_i = 1'b0;
		for (k = 0; k < 2000 && (st_l.busy !== 1'b0 || st_s.busy !== 1'b0); k++)
			@(negedge sys_clk_i);
		check("frames ended", {30'h0, st_l.busy, st_s.busy}, 32'h0);
		check("mark ends", 32'(md_cnt), 32'h21);
		check("long word", w_l, {~LONG_VOL_UP, LONG_VOL_UP, 16'ha53c});
		check("long bits", 32'(nb_l), 32'h20);
		check("long leader", 32'(ld_l), 32'h1);
		check("long mark", 32'(mk_l), 32'(MARK));
		check("bit ends", 32'(bd_cnt), 32'h20);
		check("short word", w_s, {~SHORT_VOL_UP, SHORT_VOL_UP, 8'h69, 8'h96});
		check("short bits", 32'(nb_s), 32'h20);
		check("short leader", 32'(ld_s), 32'h0);
		check("short mark", 32'(mk_s), 32'(MARK));
	endtask

	// Valid request while the radio link is up must be ignored
	task automatic test_refused;
		logic seen;
		seen = 1'b0;
		link_connected_i = 1'b1;
		command_valid_i = 1'b1;
		repeat (30)
		begin
			@(negedge sys_clk_i);
			seen = seen | st_l.busy | st_s.busy;
		end
		command_valid_i = 1'b0;
		link_connected_i = 1'b0;
		check("busy while linked", {31'h0, seen}, 32'h0);
	endtask

	// ****
	// Main sequence and watchdog
	// ****
	initial
	begin
		reset_n_i = 1'b0;
		link_connected_i = 1'b0;
		command_valid_i = 1'b0;
		req_l = '0;
		req_s = '0;
		repeat (4) @(negedge sys_clk_i);
		reset_n_i = 1'b1;
		repeat (3) @(negedge sys_clk_i);
		test_frames();
		test_refused();
		tally_and_finish();
	end

	initial
	begin
		repeat (20000) @(posedge sys_clk_i);
		n_fail++;
		tally_and_finish();
	end
endmodule

bind ir_pulse_distance_transmitter ir_tx_chk #(.ONE_CYC(ONE_CYC)) chk (.sys_clk_i(sys_clk_i),
	.reset_n_i(reset_n_i), .link_connected_i(link_connected_i),
	.command_valid_i(command_valid_i), .request_i(request_i), .ir_led_o(ir_led_o),
	.status_o(status_o));

`default_nettype wire
